/* hw/operand_address_mode_decoder.sv */
// Operand addressing-mode decoder: fetches opcode and operand bytes, forms
// the effective address. Assumes memory on the same clock, read latency 1.
//
// Behaviour
// [RQ1] Inherent instructions are one byte; opcode alone suffices.
// [RQ2] Immediate is two bytes; second byte is the operand value.
// [RQ3] Short direct takes one address byte; reach 00 - FF.
// [RQ4] Long direct takes a two-byte address; full 64 Kbyte reach.
// [RQ5] Indexed address is unsigned sum of chosen index and offset.
// [RQ6] Indexed no-offset adds no byte; index alone is address.
// [RQ7] Short indexed: one offset byte, sum up to 1FE, carry kept.
// [RQ8] Long indexed: two-byte offset plus index, full space.
// [RQ9] Short indirect: pointer address byte, one-byte pointer, page zero.
// [RQ10] Long indirect: pointer address byte, two-byte pointer, full space.
// [RQ11] Indirect indexed: index plus memory pointer; short reaches 1FE.
// [RQ12] Short forms reach page zero; memory-to-memory ops short only.
// [RQ13] Long forms reach full space, using more bytes and cycles.
// [RQ14] Seventeen modes in seven families are decoded.
// [RQ15] Mask-raise sets mask level 3; mask-lower sets level 0.
// [RQ16] Relative branches add a signed 8-bit offset to the PC.
// [RQ17] Instruction length derived from mode before execution begins.
`timescale 1ns/1ps
module operand_address_mode_decoder (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        start,
  input  wire logic [15:0] pc_in,
  input  wire logic        use_y,
  input  wire logic [7:0]  index_x,
  input  wire logic [7:0]  index_y,
  output      logic        mem_rd,
  output      logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_rdata,
  output      logic        busy,
  output      logic        done,
  output      logic [4:0]  mode,
  output      logic [7:0]  opcode,
  output      logic [2:0]  length,
  output      logic [15:0] eff_addr,
  output      logic [7:0]  operand,
  output      logic        operand_valid,
  output      logic [15:0] branch_target,
  output      logic        illegal_long,
  output      logic [1:0]  int_mask
);

  typedef enum logic [2:0] {S_IDLE, S_OPC, S_ARG1, S_ARG2, S_PTR_H, S_PTR_L,
                            S_DONE} state_t;

  fetch_if f ();

  fetch_unit u_fetch (
    .clock     (clock),
    .reset_n   (reset_n),
    .f         (f),
    .mem_rd    (mem_rd),
    .mem_addr  (mem_addr),
    .mem_rdata (mem_rdata)
  );

  state_t               state_reg;
  state_t               state_next;
  logic                 wait_reg;
  logic [15:0]          pc_reg;
  logic [7:0]           opcode_reg;
  logic [7:0]           arg1_reg;
  logic [7:0]           arg2_reg;
  logic [7:0]           ptr_hi_reg;
  logic [7:0]           ptr_lo_reg;
  logic [15:0]          eff_reg;
  logic [7:0]           operand_reg;
  logic                 opvalid_reg;
  logic [15:0]          target_reg;
  logic                 illegal_reg;
  logic [1:0]           mask_reg;
  logic                 done_reg;

  // Mode field decode; unused codes fall back to inherent
  wire logic [4:0]      mode_code = opcode_reg[amode_pkg::OPC_MODE_HI:amode_pkg::OPC_MODE_LO];
  wire amode_pkg::amode_t cur_mode =
    (mode_code < 5'(amode_pkg::MODE_COUNT)) ? amode_pkg::amode_t'(mode_code)
                                            : amode_pkg::M_INH; // see [RQ14]
  wire logic [2:0]      fn_code  = opcode_reg[amode_pkg::OPC_MODE_LO-1:0];
  wire logic [1:0]      n_extra  = amode_pkg::extra_bytes(cur_mode); // see [RQ17]
  wire logic [1:0]      n_ptr    = amode_pkg::pointer_bytes(cur_mode);
  wire logic [7:0]      index_v  = use_y ? index_y : index_x; // see [RQ5]
  wire logic [15:0]     index16  = {8'h00, index_v};

  // Base address before indexing, per mode family
  wire logic [15:0]     word_arg = {arg1_reg, arg2_reg};
  wire logic [15:0]     ptr_word = (n_ptr == 2'h2) ? {ptr_hi_reg, ptr_lo_reg}
                                                   : {8'h00, ptr_lo_reg};
  wire logic [15:0]     base_addr =
    (cur_mode == amode_pkg::M_DIR_S)  ? {8'h00, arg1_reg} :               // see [RQ3]
    (cur_mode == amode_pkg::M_DIR_L)  ? word_arg :                        // see [RQ4]
    (cur_mode == amode_pkg::M_IDX_0)  ? amode_pkg::ADDR_ZERO :            // see [RQ6]
    (cur_mode == amode_pkg::M_IDX_S)  ? {8'h00, arg1_reg} :               // see [RQ7]
    (cur_mode == amode_pkg::M_IDX_L)  ? word_arg :                        // see [RQ8]
    (cur_mode == amode_pkg::M_BIT_D || cur_mode == amode_pkg::M_BIT_DR)
                                      ? {8'h00, arg1_reg} :
    (n_ptr != 2'h0)                   ? ptr_word :                        // see [RQ9] [RQ10]
                                        amode_pkg::ADDR_ZERO;
  // 16-bit sum keeps the carry into bit eight for the short forms
  wire logic [15:0]     indexed_sum = base_addr + index16; // see [RQ7] [RQ11]
  wire logic [15:0]     final_addr  =
    amode_pkg::is_indexed(cur_mode) ? indexed_sum : base_addr;

  // Length is opcode plus extra bytes; pointer reads are not instruction bytes
  wire logic [2:0]      length_w = 3'h1 + {1'b0, n_extra}; // see [RQ1] [RQ2] [RQ13] [RQ17]

  // Relative offset: pointer byte for relative indirect, else last instruction byte
  wire logic [7:0]      rel_off = (cur_mode == amode_pkg::M_REL_I) ? ptr_lo_reg
                                : (cur_mode == amode_pkg::M_BIT_DR ||
                                   cur_mode == amode_pkg::M_BIT_IR) ? arg2_reg
                                                                    : arg1_reg;
  wire logic [15:0]     next_pc = pc_reg + 16'({1'b0, length_w});
  wire logic [15:0]     rel_target = next_pc + {{8{rel_off[7]}}, rel_off}; // see [RQ16]
  wire logic            is_rel = (cur_mode == amode_pkg::M_REL_D) ||
                                 (cur_mode == amode_pkg::M_REL_I) ||
                                 (cur_mode == amode_pkg::M_BIT_DR) ||
                                 (cur_mode == amode_pkg::M_BIT_IR);

  // Memory-to-memory work with a long form is flagged, not executed
  wire logic            long_mem = (fn_code >= amode_pkg::FN_MEM_FIRST) &&
                                   !amode_pkg::is_short(cur_mode) &&
                                   (cur_mode != amode_pkg::M_INH) &&
                                   (cur_mode != amode_pkg::M_IMM) &&
                                   !is_rel; // see [RQ12]

  // Pointer fetch addresses: high byte first, then low
  wire logic [15:0]     ptr_hi_addr = {8'h00, arg1_reg};
  wire logic [15:0]     ptr_lo_addr = (n_ptr == 2'h2) ? (ptr_hi_addr + 16'h0001)
                                                      : ptr_hi_addr;

  // One outstanding read at a time; wait_reg covers the two-cycle answer
  // No read for a byte the mode lacks; a stray answer would land in a later state
  wire logic            skip_arg = (state_reg == S_ARG1) && (n_extra == 2'h0);
  wire logic            issue = (state_reg inside {S_OPC, S_ARG1, S_ARG2, S_PTR_H,
                                                   S_PTR_L}) && !wait_reg && !skip_arg;
  assign f.req  = issue;
  assign f.addr = (state_reg == S_OPC)   ? pc_reg :
                  (state_reg == S_ARG1)  ? pc_reg + 16'h0001 :
                  (state_reg == S_ARG2)  ? pc_reg + 16'h0002 :
                  (state_reg == S_PTR_H) ? ptr_hi_addr :
                                           ptr_lo_addr;
  wire logic            got = f.rvalid;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:  if (start) state_next = S_OPC;
      S_OPC:   if (got) state_next = S_ARG1;
      S_ARG1:  begin
        if (n_extra == 2'h0) begin
          state_next = S_DONE; // see [RQ1] [RQ6]
        end else if (got) begin
          state_next = (n_extra == 2'h2) ? S_ARG2 :
                       (n_ptr == 2'h2)   ? S_PTR_H :
                       (n_ptr == 2'h1)   ? S_PTR_L : S_DONE;
        end
      end
      S_ARG2:  if (got) state_next = (n_ptr != 2'h0) ? S_PTR_L : S_DONE; // see [RQ17]
      S_PTR_H: if (got) state_next = S_PTR_L; // see [RQ10]
      S_PTR_L: if (got) state_next = S_DONE;  // see [RQ9]
      S_DONE:  state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= S_IDLE;
      wait_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      wait_reg  <= (state_next != state_reg) ? 1'b0 : (wait_reg | issue);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pc_reg     <= amode_pkg::ADDR_ZERO;
      opcode_reg <= 8'h00;
      arg1_reg   <= 8'h00;
      arg2_reg   <= 8'h00;
      ptr_hi_reg <= 8'h00;
      ptr_lo_reg <= 8'h00;
    end else begin
      if (state_reg == S_IDLE && start) begin
        pc_reg     <= pc_in;
        arg1_reg   <= 8'h00;
        arg2_reg   <= 8'h00;
        ptr_hi_reg <= 8'h00;
        ptr_lo_reg <= 8'h00;
      end
      if (got && state_reg == S_OPC)   opcode_reg <= f.rdata;
      if (got && state_reg == S_ARG1)  arg1_reg   <= f.rdata;
      if (got && state_reg == S_ARG2)  arg2_reg   <= f.rdata;
      if (got && state_reg == S_PTR_H) ptr_hi_reg <= f.rdata;
      if (got && state_reg == S_PTR_L) ptr_lo_reg <= f.rdata;
    end
  end

  // Results are latched on the decision cycle and held until the next decode reaches S_DONE
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      eff_reg     <= amode_pkg::ADDR_ZERO;
      operand_reg <= 8'h00;
      opvalid_reg <= 1'b0;
      target_reg  <= amode_pkg::ADDR_ZERO;
      illegal_reg <= 1'b0;
      done_reg    <= 1'b0;
    end else begin
      done_reg <= (state_reg == S_DONE);
      if (state_reg == S_DONE) begin
        eff_reg     <= final_addr;
        operand_reg <= arg1_reg;                              // see [RQ2]
        opvalid_reg <= (cur_mode == amode_pkg::M_IMM);        // see [RQ2]
        target_reg  <= is_rel ? rel_target : next_pc;         // see [RQ16]
        illegal_reg <= long_mem;                              // see [RQ12]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mask_reg <= amode_pkg::MASK_RESET;
    end else if (state_reg == S_DONE && cur_mode == amode_pkg::M_INH) begin
      if (fn_code == amode_pkg::FN_MASK_RAISE) begin
        mask_reg <= amode_pkg::MASK_RAISED;  // see [RQ15]
      end else if (fn_code == amode_pkg::FN_MASK_LOWER) begin
        mask_reg <= amode_pkg::MASK_LOWERED; // see [RQ15]
      end
    end
  end

  assign busy          = (state_reg != S_IDLE);
  assign done          = done_reg;
  assign mode          = mode_code;
  assign opcode        = opcode_reg;
  assign length        = length_w;
  assign eff_addr      = eff_reg;
  assign operand       = operand_reg;
  assign operand_valid = opvalid_reg;
  assign branch_target = target_reg;
  assign illegal_long  = illegal_reg;
  assign int_mask      = mask_reg;

endmodule // operand_address_mode_decoder

/* pkg/amode_pkg.sv */
// Addressing-mode decoder constants: modes, lengths and the opcode classification.
// Assumes a byte-wide program/data memory with a one-cycle registered read.
package amode_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Addressing modes, seventeen in seven families
  typedef enum logic [4:0] {
    M_INH,          // inherent
    M_IMM,          // immediate
    M_DIR_S,        // direct short
    M_DIR_L,        // direct long
    M_IDX_0,        // indexed, no offset
    M_IDX_S,        // indexed short
    M_IDX_L,        // indexed long
    M_IND_S,        // indirect short
    M_IND_L,        // indirect long
    M_INDX_S,       // indirect indexed short
    M_INDX_L,       // indirect indexed long
    M_REL_D,        // relative direct
    M_REL_I,        // relative indirect
    M_BIT_D,        // bit direct
    M_BIT_I,        // bit indirect
    M_BIT_DR,       // bit direct relative
    M_BIT_IR        // bit indirect relative
  } amode_t;

  localparam int MODE_COUNT = 17;

  // Bytes that follow the opcode, per mode
  function automatic logic [1:0] extra_bytes(input amode_t m);
    case (m)
      M_INH, M_IDX_0:                          extra_bytes = 2'h0;
      M_IMM, M_DIR_S, M_IDX_S, M_IND_S, M_IND_L,
      M_INDX_S, M_INDX_L, M_REL_D, M_REL_I,
      M_BIT_D, M_BIT_I:                        extra_bytes = 2'h1;
      M_DIR_L, M_IDX_L, M_BIT_DR, M_BIT_IR:    extra_bytes = 2'h2;
      default:                                 extra_bytes = 2'h0;
    endcase
  endfunction

  // Pointer word width fetched from memory (0 none, 1 byte, 2 word)
  function automatic logic [1:0] pointer_bytes(input amode_t m);
    case (m)
      M_IND_S, M_INDX_S, M_REL_I, M_BIT_I, M_BIT_IR: pointer_bytes = 2'h1;
      M_IND_L, M_INDX_L:                             pointer_bytes = 2'h2;
      default:                                       pointer_bytes = 2'h0;
    endcase
  endfunction

  // Modes that add an index register
  function automatic logic is_indexed(input amode_t m);
    is_indexed = (m == M_IDX_0) || (m == M_IDX_S) || (m == M_IDX_L) ||
                 (m == M_INDX_S) || (m == M_INDX_L);
  endfunction

  // Short forms: one-byte address, offset or pointer, page zero plus index
  function automatic logic is_short(input amode_t m);
    is_short = (m == M_DIR_S) || (m == M_IDX_0) || (m == M_IND_S) ||
               (m == M_IDX_S) || (m == M_INDX_S) ||
               (m == M_BIT_D) || (m == M_BIT_I) || (m == M_BIT_DR) ||
               (m == M_BIT_IR);
  endfunction

  // Interrupt mask levels
  localparam logic [1:0] MASK_RAISED  = 2'h3;
  localparam logic [1:0] MASK_LOWERED = 2'h0;
  localparam logic [1:0] MASK_RESET   = 2'h3;

  // Opcode field layout: [7:3] mode, [2:0] function within the mode
  localparam int OPC_MODE_HI = 7;
  localparam int OPC_MODE_LO = 3;

  // Function codes within the inherent mode
  localparam logic [2:0] FN_MASK_RAISE = 3'h1;
  localparam logic [2:0] FN_MASK_LOWER = 3'h2;

  // Function codes marking memory-to-memory work (short forms only)
  localparam logic [2:0] FN_MEM_FIRST = 3'h4;

  localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] PAGE0_MASK = 16'h00ff;

endpackage

/* pkg/fetch_if.sv */
// Memory fetch request/answer pair between decoder core and fetch unit.
// Assumes a single clock; valid answers arrive two cycles after a request.
`timescale 1ns/1ps
interface fetch_if;
  logic        req;
  logic [15:0] addr;
  logic        rvalid;
  logic [7:0]  rdata;

  modport core  (output req, output addr, input rvalid, input rdata);
  modport unit  (input req, input addr, output rvalid, output rdata);
endinterface

/* hw/fetch_unit.sv */
// Fetch unit: forwards core requests to the memory pins, registers the data.
// Assumes memory answers in the cycle after mem_rd is high.
`timescale 1ns/1ps
module fetch_unit (
  input  wire logic        clock,
  input  wire logic        reset_n,
  fetch_if.unit            f,
  output      logic        mem_rd,
  output      logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_rdata
);

  logic pending_reg;

  assign mem_rd   = f.req;
  assign mem_addr = f.addr;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pending_reg <= 1'b0;
      f.rdata     <= 8'h00;
    end else begin
      pending_reg <= f.req;
      if (pending_reg) begin
        f.rdata <= mem_rdata;
      end
    end
  end

  // Data register lands one cycle after capture; valid tracks it
  logic valid_reg;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= pending_reg;
    end
  end
  assign f.rvalid = valid_reg;

endmodule // fetch_unit

/* dv/amode_monitor.sv */
// Assertion checker for the operand addressing-mode decoder top ports.
// Assumes one clock domain, synchronous active-low reset; bound at the foot.
`timescale 1ns/1ps
module amode_monitor (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        start,
  input wire logic        use_y,
  input wire logic [7:0]  index_x,
  input wire logic [7:0]  index_y,
  input wire logic        busy,
  input wire logic        done,
  input wire logic [4:0]  mode,
  input wire logic [7:0]  opcode,
  input wire logic [2:0]  length,
  input wire logic [15:0] eff_addr,
  input wire logic        operand_valid,
  input wire logic [1:0]  int_mask
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire [7:0] idx_sel = use_y ? index_y : index_x;
  // Unused mode codes fall back to inherent
  wire       fin_inh = done && (mode == amode_pkg::M_INH || mode > 5'h10);

  AST_INH_LEN: assert property (fin_inh |-> length == 3'h1)
    else $error("inherent length not one");
  AST_IMM_OPERAND: assert property (
    done && mode == amode_pkg::M_IMM |-> operand_valid && length == 3'h2)
    else $error("immediate operand not flagged");
  AST_DIR_S_PAGE0: assert property (
    done && mode == amode_pkg::M_DIR_S |-> eff_addr[15:8] == 8'h00 && length == 3'h2)
    else $error("short direct left page zero");
  AST_IDX0_ADDR: assert property (
    // Index was read on the edge before done
    done && mode == amode_pkg::M_IDX_0
    |-> eff_addr == {8'h00, $past(idx_sel)} && length == 3'h1)
    else $error("no-offset indexed address wrong");
  AST_IDX_S_RANGE: assert property (
    done && mode == amode_pkg::M_IDX_S |-> eff_addr <= 16'h01fe && length == 3'h2)
    else $error("short indexed out of range");
  AST_MASK_LEVEL: assert property (
    done && mode == amode_pkg::M_INH && opcode[2:0] inside {3'h1, 3'h2}
    |-> int_mask == (opcode[0] ? amode_pkg::MASK_RAISED : amode_pkg::MASK_LOWERED))
    else $error("mask level wrong");
  AST_DONE_BOUND: assert property (start && !busy |-> ##[1:40] done)
    else $error("decode did not finish");
  AST_DONE_PULSE: assert property (done |=> !done)
    else $error("done longer than one cycle");

  cover property (done && mode == amode_pkg::M_IMM);
  cover property (done && mode == amode_pkg::M_IDX_S && eff_addr > 16'h00ff);
  cover property (done && int_mask == amode_pkg::MASK_LOWERED);
endmodule // amode_monitor

bind operand_address_mode_decoder amode_monitor mon (
  .clock(clock), .reset_n(reset_n), .start(start), .use_y(use_y), .index_x(index_x),
  .index_y(index_y), .busy(busy), .done(done), .mode(mode), .opcode(opcode),
  .length(length), .eff_addr(eff_addr), .operand_valid(operand_valid), .int_mask(int_mask)
);

/* dv/prog_mem_model.sv */
// Program and data memory model answering the decoder's byte reads.
// Assumes data is wanted only in the cycle after a read strobe.
`timescale 1ns/1ps
module prog_mem_model (
  input  wire logic        clock,
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  output      logic [7:0]  mem_rdata
);
  logic [7:0] cells [0:65535];
  logic [7:0] last_reg = 8'h00;
  logic       valid_reg = 1'b0;

  always_ff @(posedge clock) begin
    valid_reg <= mem_rd;
    if (mem_rd) last_reg <= cells[mem_addr];
  end
  // Stale data is inverted so a late capture never matches by luck
  assign mem_rdata = valid_reg ? last_reg : ~last_reg;
endmodule // prog_mem_model

/* dv/tb.sv */
// Self-checking bench for the addressing-mode decoder against a memory model.
// Assumes 10 MHz clock, synchronous active-low reset, one decode at a time.
`timescale 1ns/1ps
module tb;
  logic        clock, reset_n, start, use_y, mem_rd, busy, done, operand_valid, illegal_long;
  logic [15:0] pc_in, mem_addr, eff_addr, branch_target;
  logic [7:0]  index_x, index_y, mem_rdata, opcode, operand;
  logic [4:0]  mode;
  logic [2:0]  length;
  logic [1:0]  int_mask;
  int          err_count, comparisons, exp_mask;
  int          len_tab [17] = '{1, 2, 2, 3, 1, 2, 3, 2, 2, 2, 2, 2, 2, 2, 2, 3, 3};

  operand_address_mode_decoder uut (
    .clock(clock), .reset_n(reset_n), .start(start), .pc_in(pc_in), .use_y(use_y),
    .index_x(index_x), .index_y(index_y), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .busy(busy), .done(done), .mode(mode), .opcode(opcode),
    .length(length), .eff_addr(eff_addr), .operand(operand),
    .operand_valid(operand_valid), .branch_target(branch_target),
    .illegal_long(illegal_long), .int_mask(int_mask));
  prog_mem_model mem (.clock(clock), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic check(input string what, input logic [15:0] got, input int exp);
    comparisons++;
    if (got !== 16'(exp)) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, 16'(exp), got);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic run(input logic [7:0] opc, b1, b2, p0, p1, ix, input bit poke);
    int m, e, off, k;
    logic [15:0] pc;
    pc = 16'h4000 + 16'($urandom % 12288);
    m = (opc[7:3] > 5'h10) ? 0 : int'(opc[7:3]);
    // Unselected index holds the inverse so a wrong pick shows
    use_y = 1'($urandom);
    index_x = use_y ? ~ix : ix;
    index_y = use_y ? ix : ~ix;
    mem.cells[pc] = opc;
    mem.cells[pc + 16'h1] = b1;
    mem.cells[pc + 16'h2] = b2;
    mem.cells[{8'h00, b1}] = p0;
    mem.cells[{8'h00, b1} + 16'h1] = p1;
    pc_in = pc;
    start = 1'b1;
    @(negedge clock);
    check("busy", 16'(busy), 1);
    // A second start mid-decode must be ignored
    for (k = 0; k < 60 && done !== 1'b1; k++) begin
      start = poke && k == 2;
      if (start) pc_in = 16'h0000;
      @(negedge clock);
    end
    if (k == 60) begin
      $display("[FAIL] done expected 1 seen 0");
      err_count++;
      close_out();
    end
    case (m)
      2, 13, 15: e = b1;
      3: e = {b1, b2};
      4: e = ix;
      5: e = b1 + ix;
      6: e = {b1, b2} + ix;
      7, 14, 16: e = p0;
      8: e = {p0, p1};
      9: e = p0 + ix;
      10: e = {p0, p1} + ix;
      default: e = -1;
    endcase
    case (m)
      11: off = b1;
      12: off = p0;
      15, 16: off = b2;
      default: off = 0;
    endcase
    if (off > 127) off -= 256;
    if (m == 0 && opc[2:0] == 3'h1) exp_mask = 3;
    if (m == 0 && opc[2:0] == 3'h2) exp_mask = 0;
    check("length", 16'(length), len_tab[m]);
    check("mode", 16'(mode), opc[7:3]);
    check("opcode", 16'(opcode), opc);
    if (e >= 0) check("eff_addr", eff_addr, e);
    check("branch_target", branch_target, pc + len_tab[m] + off);
    check("operand_valid", 16'(operand_valid), m == 1);
    if (m == 1) check("operand", 16'(operand), b1);
    check("int_mask", 16'(int_mask), exp_mask);
    check("illegal_long", 16'(illegal_long), opc[2] && m inside {3, 6, 8, 10});
  endtask

  task automatic do_reset();
    reset_n = 1'b0;
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    exp_mask = 3;
    check("int_mask", 16'(int_mask), 3);
    check("done", 16'(done), 0);
    check("busy", 16'(busy), 0);
    check("mem_rd", 16'(mem_rd), 0);
  endtask

  initial begin
    start = 1'b0;
    use_y = 1'b0;
    pc_in = 16'h0000;
    index_x = 8'h00;
    index_y = 8'h00;
    err_count = 0;
    comparisons = 0;
    void'($urandom(32'h5c75838d));
    do_reset();
    $display("test reset done");
    for (int m = 0; m < 17; m++) begin
      for (int r = 0; r < 3; r++) begin
        run({5'(m), 3'($urandom)}, 8'($urandom % 240), 8'($urandom), 8'($urandom),
            8'($urandom), 8'($urandom), 1'b0);
      end
    end
    $display("test all_modes done");
    run(8'h28, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 1'b0);
    run(8'h48, 8'h20, 8'h00, 8'hff, 8'h00, 8'hff, 1'b0);
    run(8'h30, 8'hff, 8'hf0, 8'h00, 8'h00, 8'h20, 1'b0);
    run(8'h58, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    run(8'h60, 8'h30, 8'h00, 8'h81, 8'h00, 8'h00, 1'b0);
    run(8'hf8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    $display("test boundaries done");
    run(8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    run(8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    run(8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    do_reset();
    $display("test mask done");
    run(8'h1c, 8'h12, 8'h34, 8'h00, 8'h00, 8'h00, 1'b0);
    run(8'h15, 8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    run(8'h47, 8'h40, 8'h00, 8'h12, 8'h34, 8'h05, 1'b0);
    $display("test mem_to_mem done");
    run(8'h18, 8'hab, 8'hcd, 8'h00, 8'h00, 8'h00, 1'b1);
    $display("test refused done");
    close_out();
  end
endmodule // tb
